// ===== eal_pkg.sv
// eal_pkg.sv: constants, operation codes and carrier types of the 8-bit arithmetic/logic unit.
// assumes: compiled before eal_alu and eal_unit; one clock, AXI4-Lite register access.
`default_nettype none
package eal_pkg;

  localparam int EAL_AW = 8;
  localparam int EAL_DW = 32;
  localparam int EAL_BYTE = 8;
  localparam int EAL_NIB = 4;
  localparam int EAL_B_MSB = 7;
  localparam int EAL_W_MSB = 15;
  localparam logic [7:0] EAL_ALL_ONES = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [EAL_AW-1:0] EAL_WORD_MASK = 8'hFC;
  localparam logic [EAL_AW-1:0] EAL_OFS_CTRL = 8'h00;
  localparam logic [EAL_AW-1:0] EAL_OFS_OPER = 8'h04;
  localparam logic [EAL_AW-1:0] EAL_OFS_FLAGS = 8'h08;
  localparam logic [EAL_AW-1:0] EAL_OFS_RESULT = 8'h0C;
  localparam logic [EAL_AW-1:0] EAL_OFS_STATUS = 8'h10;

  localparam int EAL_CTRL_OP = 0;
  localparam int EAL_OPW = 5;
  localparam int EAL_CTRL_GO = 8;
  localparam int EAL_OPER_LO = 0;
  localparam int EAL_OPER_HI = 8;
  localparam int EAL_OPER_SRC = 16;
  localparam int EAL_RES_W = 16;
  localparam int EAL_ST_BUSY = 0;
  localparam int EAL_ST_DONE = 1;
  localparam int EAL_ST_REFUSED = 2;

  // condition flag positions
  localparam int EAL_FLW = 6;
  localparam int EAL_FLG_C = 0;
  localparam int EAL_FLG_Z = 1;
  localparam int EAL_FLG_N = 2;
  localparam int EAL_FLG_V = 3;
  localparam int EAL_FLG_S = 4;
  localparam int EAL_FLG_H = 5;

  localparam logic [1:0] EAL_CYC_SHORT = 2'h1;
  localparam logic [1:0] EAL_CYC_LONG = 2'h2;
  localparam logic [1:0] EAL_RESP_OKAY = 2'h0;
  localparam logic [1:0] EAL_RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////////////////
  typedef enum logic [4:0] {
    EAL_OP_SUM_REGS = 5'h00, EAL_OP_SUM_CARRY_REGS = 5'h01, EAL_OP_WORD_IMM_SUM = 5'h02,
    EAL_OP_DIFF_REGS = 5'h03, EAL_OP_DIFF_CONST = 5'h04, EAL_OP_DIFF_BORROW_REGS = 5'h05,
    EAL_OP_DIFF_BORROW_CONST = 5'h06, EAL_OP_WORD_IMM_DIFF = 5'h07, EAL_OP_CONJ_REGS = 5'h08,
    EAL_OP_CONJ_WITH_CONST = 5'h09, EAL_OP_DISJ_REGS = 5'h0A, EAL_OP_DISJ_WITH_CONST = 5'h0B,
    EAL_OP_XOR_REGS = 5'h0C, EAL_OP_INVERT = 5'h0D, EAL_OP_SET_MASK_BITS = 5'h0E,
    EAL_OP_CLEAR_MASK_BITS = 5'h0F, EAL_OP_ZERO_SIGN_CHECK = 5'h10, EAL_OP_ZERO_FILL = 5'h11,
    EAL_OP_UNSIGNED_PRODUCT = 5'h12, EAL_OP_SIGNED_PRODUCT = 5'h13,
    EAL_OP_MIXED_SIGN_PRODUCT = 5'h14
  } eal_op_t;

  typedef enum logic {EAL_IDLE = 1'h0, EAL_EXEC = 1'h1} eal_phase_t;

  typedef struct packed {
    eal_op_t op;
    logic [7:0] a_lo;
    logic [7:0] a_hi;
    logic [7:0] b;
    logic [EAL_FLW-1:0] flags;
  } eal_alu_in_t;

  typedef struct packed {
    logic [EAL_RES_W-1:0] res;
    logic [EAL_FLW-1:0] flags;
  } eal_alu_out_t;

  typedef struct packed {
    logic awvalid;
    logic [EAL_AW-1:0] awaddr;
    logic wvalid;
    logic [EAL_DW-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [EAL_AW-1:0] araddr;
    logic rready;
  } eal_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [EAL_DW-1:0] rdata;
    logic [1:0] rresp;
  } eal_axi_rsp_t;

  function automatic logic eal_op_legal(input eal_op_t op);
    return op <= EAL_OP_MIXED_SIGN_PRODUCT;
  endfunction

  function automatic logic eal_op_word(input eal_op_t op);
    return (op == EAL_OP_WORD_IMM_SUM) || (op == EAL_OP_WORD_IMM_DIFF);
  endfunction

  function automatic logic eal_op_product(input eal_op_t op);
    return (op >= EAL_OP_UNSIGNED_PRODUCT) && eal_op_legal(op);
  endfunction

  function automatic logic [1:0] eal_op_cycles(input eal_op_t op);
    return (eal_op_word(op) || eal_op_product(op)) ? EAL_CYC_LONG : EAL_CYC_SHORT;
  endfunction

endpackage
`default_nettype wire

// ===== eal_alu.sv
// eal_alu.sv: combinational result and flag datapath of the arithmetic/logic unit.
// assumes: operands and incoming flags are held stable by the caller for the whole operation.
`timescale 1ns/100ps
`default_nettype none
module eal_alu (
  input wire eal_pkg::eal_alu_in_t alu_in,
  output var eal_pkg::eal_alu_out_t alu_out
);
  import eal_pkg::*;

  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] r8;
  logic [8:0] s9;
  logic [4:0] h5;
  logic [16:0] w17;
  logic [15:0] wv;
  logic cu;
  logic byte_zn;

  always_comb begin
    a = alu_in.a_lo;
    b = alu_in.b;
    wv = {alu_in.a_hi, alu_in.a_lo};
    cu = 1'b0;
    s9 = '0;
    h5 = '0;
    w17 = '0;
    r8 = '0;
    byte_zn = 1'b1;
    alu_out.res = '0;
    // flags an operation does not name pass through unchanged
    alu_out.flags = alu_in.flags;
    unique case (alu_in.op)
      EAL_OP_SUM_REGS, EAL_OP_SUM_CARRY_REGS: begin
        cu = alu_in.flags[EAL_FLG_C] & (alu_in.op == EAL_OP_SUM_CARRY_REGS);
        s9 = {1'b0, a} + {1'b0, b} + {8'h00, cu};
        h5 = {1'b0, a[EAL_NIB-1:0]} + {1'b0, b[EAL_NIB-1:0]} + {4'h0, cu};
        r8 = s9[EAL_B_MSB:0];
        alu_out.flags[EAL_FLG_C] = s9[EAL_BYTE];
        alu_out.flags[EAL_FLG_H] = h5[EAL_NIB];
        alu_out.flags[EAL_FLG_V] = (a[EAL_B_MSB] == b[EAL_B_MSB]) &&
          (r8[EAL_B_MSB] != a[EAL_B_MSB]);
      end
      EAL_OP_DIFF_REGS, EAL_OP_DIFF_CONST, EAL_OP_DIFF_BORROW_REGS,
      EAL_OP_DIFF_BORROW_CONST: begin
        cu = alu_in.flags[EAL_FLG_C] & ((alu_in.op == EAL_OP_DIFF_BORROW_REGS) ||
                                        (alu_in.op == EAL_OP_DIFF_BORROW_CONST));
        s9 = {1'b0, a} - {1'b0, b} - {8'h00, cu};
        h5 = {1'b0, a[EAL_NIB-1:0]} - {1'b0, b[EAL_NIB-1:0]} - {4'h0, cu};
        r8 = s9[EAL_B_MSB:0];
        alu_out.flags[EAL_FLG_C] = s9[EAL_BYTE];
        alu_out.flags[EAL_FLG_H] = h5[EAL_NIB];
        alu_out.flags[EAL_FLG_V] = (a[EAL_B_MSB] != b[EAL_B_MSB]) &&
          (r8[EAL_B_MSB] != a[EAL_B_MSB]);
      end
      EAL_OP_WORD_IMM_SUM, EAL_OP_WORD_IMM_DIFF: begin
        byte_zn = 1'b0;
        if (alu_in.op == EAL_OP_WORD_IMM_SUM) begin
          w17 = {1'b0, wv} + {9'h000, b};
        end else begin
          w17 = {1'b0, wv} - {9'h000, b};
        end
        alu_out.res = w17[EAL_W_MSB:0];
        alu_out.flags[EAL_FLG_C] = w17[EAL_RES_W];
        alu_out.flags[EAL_FLG_Z] = alu_out.res == '0;
        alu_out.flags[EAL_FLG_N] = alu_out.res[EAL_W_MSB];
        alu_out.flags[EAL_FLG_V] = (wv[EAL_W_MSB] != alu_out.res[EAL_W_MSB]) &&
                                   (wv[EAL_W_MSB] == (alu_in.op == EAL_OP_WORD_IMM_DIFF));
        alu_out.flags[EAL_FLG_S] = alu_out.flags[EAL_FLG_N] ^ alu_out.flags[EAL_FLG_V];
      end
      EAL_OP_CONJ_REGS, EAL_OP_CONJ_WITH_CONST: begin
        r8 = a & b;
        alu_out.flags[EAL_FLG_V] = 1'b0;
      end
      EAL_OP_DISJ_REGS, EAL_OP_DISJ_WITH_CONST, EAL_OP_SET_MASK_BITS: begin
        r8 = a | b;
        alu_out.flags[EAL_FLG_V] = 1'b0;
      end
      EAL_OP_XOR_REGS, EAL_OP_ZERO_FILL: begin
        // zero fill is the destination combined with itself, so b is ignored there
        r8 = (alu_in.op == EAL_OP_ZERO_FILL) ? (a ^ a) : (a ^ b);
        alu_out.flags[EAL_FLG_V] = 1'b0;
      end
      EAL_OP_INVERT: begin
        r8 = EAL_ALL_ONES - a;
        alu_out.flags[EAL_FLG_C] = 1'b1;
        alu_out.flags[EAL_FLG_V] = 1'b0;
      end
      EAL_OP_CLEAR_MASK_BITS: begin
        r8 = a & (EAL_ALL_ONES - b);
        alu_out.flags[EAL_FLG_V] = 1'b0;
      end
      EAL_OP_ZERO_SIGN_CHECK: begin
        r8 = a & a;
        alu_out.flags[EAL_FLG_V] = 1'b0;
      end
      EAL_OP_UNSIGNED_PRODUCT, EAL_OP_SIGNED_PRODUCT, EAL_OP_MIXED_SIGN_PRODUCT: begin
        byte_zn = 1'b0;
        // low half of a product of sign-extended operands equals the signed product
        if (alu_in.op == EAL_OP_UNSIGNED_PRODUCT) begin
          alu_out.res = {8'h00, a} * {8'h00, b};
        end else if (alu_in.op == EAL_OP_SIGNED_PRODUCT) begin
          alu_out.res = {{EAL_BYTE{a[EAL_B_MSB]}}, a} * {{EAL_BYTE{b[EAL_B_MSB]}}, b};
        end else begin
          alu_out.res = {{EAL_BYTE{a[EAL_B_MSB]}}, a} * {8'h00, b};
        end
        alu_out.flags[EAL_FLG_C] = alu_out.res[EAL_W_MSB];
        alu_out.flags[EAL_FLG_Z] = alu_out.res == '0;
      end
      default: begin
        byte_zn = 1'b0;
      end
    endcase
    if (byte_zn) begin
      alu_out.res = {8'h00, r8};
      alu_out.flags[EAL_FLG_Z] = r8 == '0;
      alu_out.flags[EAL_FLG_N] = r8[EAL_B_MSB];
    end
  end

endmodule
`default_nettype wire

// ===== eal_unit.sv
// eal_unit.sv: 8-bit arithmetic/logic unit with its operand, flag and result registers
// behind an AXI4-Lite slave.
// assumes: a single master on the same clock; synchronous active-low reset.
//
// Functional notes
// - add source to destination, carry variant adds carry; Z C N V H, one cycle.
// - word sum adds constant to 16-bit pair; Z C N V S, two cycles.
// - constant difference subtracts constant from destination in one cycle; Z C N V H.
// - register difference, borrow variant also subtracts carry; one cycle; Z C N V H.
// - borrow constant difference subtracts constant and carry in one cycle; Z C N V H.
// - word difference subtracts constant from 16-bit pair; Z C N V S, two cycles.
// - AND with register or constant, one cycle, only Z N V change.
// - OR and XOR write result in one cycle, only Z N V change.
// - set mask bits ORs constant into destination in one cycle; Z N V.
// - clear mask bits ANDs with all-ones minus mask in one cycle; Z N V.
// - zero-sign check ANDs register with itself, flags Z N show its value, V is cleared.
// - invert gives all-ones minus value in one cycle; Z C N V.
// - zero fill XORs register with itself, one cycle, Z N V.
// - three products write 16 bits to product pair in two cycles; only Z C.
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module eal_unit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire eal_pkg::eal_axi_req_t axi_req,
  output wire eal_pkg::eal_axi_rsp_t axi_rsp
);
  import eal_pkg::*;

  typedef struct packed {
    eal_phase_t phase;
    logic [1:0] cnt;
    eal_alu_in_t lat;
    logic [EAL_OPW-1:0] ctrl_op;
    logic [7:0] dst_lo;
    logic [7:0] dst_hi;
    logic [7:0] src;
    logic [EAL_FLW-1:0] flags;
    logic [EAL_RES_W-1:0] res;
    logic done;
    logic refused;
    logic aw_held;
    logic [EAL_AW-1:0] awaddr;
    logic w_held;
    logic [EAL_DW-1:0] wdata;
    logic [3:0] wstrb;
    eal_axi_rsp_t rsp;
  } eal_state_t;

  eal_state_t st_q;
  eal_state_t st_d;
  eal_alu_out_t alu_out;
  logic [EAL_DW-1:0] wmask;
  logic [EAL_DW-1:0] rd_word;
  logic [EAL_DW-1:0] wr_old;
  logic [EAL_DW-1:0] wr_new;
  logic [EAL_DW-1:0] wr_set;
  logic rd_err;
  logic wr_err;
  logic busy;
  logic wr_fire;
  logic start;
  logic commit;
  eal_op_t new_op;

  function automatic logic [EAL_DW:0] reg_view(input eal_state_t s, input logic [EAL_AW-1:0] a);
    logic [EAL_DW-1:0] v;
    logic e;
    v = '0;
    e = 1'b0;
    case (a & EAL_WORD_MASK)
      EAL_OFS_CTRL: v[EAL_CTRL_OP +: EAL_OPW] = s.ctrl_op;
      EAL_OFS_OPER: begin
        v[EAL_OPER_LO +: EAL_BYTE] = s.dst_lo;
        v[EAL_OPER_HI +: EAL_BYTE] = s.dst_hi;
        v[EAL_OPER_SRC +: EAL_BYTE] = s.src;
      end
      EAL_OFS_FLAGS: v[EAL_FLW-1:0] = s.flags;
      EAL_OFS_RESULT: v[EAL_RES_W-1:0] = s.res;
      EAL_OFS_STATUS: begin
        v[EAL_ST_BUSY] = s.phase == EAL_EXEC;
        v[EAL_ST_DONE] = s.done;
        v[EAL_ST_REFUSED] = s.refused;
      end
      default: e = 1'b1;
    endcase
    return {e, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////
  // byte-lane mask from the held write strobes
  for (genvar gi = 0; gi < EAL_DW / EAL_BYTE; gi++) begin : g_lane
    assign wmask[gi*EAL_BYTE +: EAL_BYTE] = {EAL_BYTE{st_q.wstrb[gi]}};
  end

  assign {rd_err, rd_word} = reg_view(st_q, axi_req.araddr);
  assign {wr_err, wr_old} = reg_view(st_q, st_q.awaddr);
  assign wr_new = (wr_old & ~wmask) | (st_q.wdata & wmask);
  assign wr_set = st_q.wdata & wmask;
  assign new_op = eal_op_t'(wr_new[EAL_CTRL_OP +: EAL_OPW]);
  assign busy = st_q.phase == EAL_EXEC;
  assign axi_rsp = st_q.rsp;

  eal_alu u_alu (
    .alu_in(st_q.lat),
    .alu_out(alu_out)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    start = 1'b0;
    commit = 1'b0;
    wr_fire = 1'b0;

    // read channel: one outstanding read, answered the cycle after the address is taken
    if (st_q.rsp.rvalid && axi_req.rready) begin
      st_d.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && st_q.rsp.arready) begin
      st_d.rsp.rvalid = 1'b1;
      st_d.rsp.rdata = rd_word;
      st_d.rsp.rresp = rd_err ? EAL_RESP_SLVERR : EAL_RESP_OKAY;
    end
    st_d.rsp.arready = !st_d.rsp.rvalid;

    // write channel: address and data are held independently, acted on once both are in
    if (axi_req.awvalid && st_q.rsp.awready) begin
      st_d.aw_held = 1'b1;
      st_d.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st_q.rsp.wready) begin
      st_d.w_held = 1'b1;
      st_d.wdata = axi_req.wdata;
      st_d.wstrb = axi_req.wstrb;
    end
    if (st_q.rsp.bvalid && axi_req.bready) begin
      st_d.rsp.bvalid = 1'b0;
    end
    if (st_q.aw_held && st_q.w_held && !st_q.rsp.bvalid) begin
      wr_fire = 1'b1;
      st_d.aw_held = 1'b0;
      st_d.w_held = 1'b0;
      st_d.rsp.bvalid = 1'b1;
      st_d.rsp.bresp = wr_err ? EAL_RESP_SLVERR : EAL_RESP_OKAY;
    end
    st_d.rsp.awready = !st_d.aw_held && !st_d.rsp.bvalid;
    st_d.rsp.wready = !st_d.w_held && !st_d.rsp.bvalid;

    // register effects; operands and flags are frozen while an operation runs
    if (wr_fire && !wr_err) begin
      case (st_q.awaddr & EAL_WORD_MASK)
        EAL_OFS_CTRL: begin
          st_d.ctrl_op = wr_new[EAL_CTRL_OP +: EAL_OPW];
          if (wr_set[EAL_CTRL_GO]) begin
            if (busy || !eal_op_legal(new_op)) begin
              st_d.refused = 1'b1;
            end else begin
              start = 1'b1;
            end
          end
        end
        EAL_OFS_OPER: begin
          if (busy) begin
            st_d.refused = 1'b1;
          end else begin
            st_d.dst_lo = wr_new[EAL_OPER_LO +: EAL_BYTE];
            st_d.dst_hi = wr_new[EAL_OPER_HI +: EAL_BYTE];
            st_d.src = wr_new[EAL_OPER_SRC +: EAL_BYTE];
          end
        end
        EAL_OFS_FLAGS: begin
          if (busy) begin
            st_d.refused = 1'b1;
          end else begin
            st_d.flags = wr_new[EAL_FLW-1:0];
          end
        end
        EAL_OFS_STATUS: begin
          // write one to clear; a completion in the same cycle is set again below
          st_d.done = st_q.done & ~wr_set[EAL_ST_DONE];
          st_d.refused = st_q.refused & ~wr_set[EAL_ST_REFUSED];
        end
        default: begin
        end
      endcase
    end

    if (start) begin
      st_d.phase = EAL_EXEC;
      st_d.cnt = eal_op_cycles(new_op) - EAL_CYC_SHORT;
      st_d.lat.op = new_op;
      st_d.lat.a_lo = st_q.dst_lo;
      st_d.lat.a_hi = st_q.dst_hi;
      st_d.lat.b = st_q.src;
      st_d.lat.flags = st_q.flags;
    end

    // execution: flags, result and destination (except for products) change at the same final edge
    unique case (st_q.phase)
      EAL_IDLE: begin
      end
      EAL_EXEC: begin
        if (st_q.cnt == '0) begin
          commit = 1'b1;
          st_d.phase = EAL_IDLE;
          st_d.flags = alu_out.flags;
          st_d.res = alu_out.res;
          st_d.done = 1'b1;
          if (eal_op_word(st_q.lat.op)) begin
            {st_d.dst_hi, st_d.dst_lo} = alu_out.res;
          end else if (!eal_op_product(st_q.lat.op)) begin
            st_d.dst_lo = alu_out.res[EAL_B_MSB:0];
          end
        end else begin
          st_d.cnt = st_q.cnt - EAL_CYC_SHORT;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // checks on the latched operands against independent arithmetic
  logic [7:0] la;
  logic [7:0] lb;
  logic [15:0] lw;
  logic lc;
  eal_op_t lop;
  logic [EAL_FLW-1:0] af;
  logic [EAL_FLW-1:0] lf;
  logic [15:0] ares;
  logic [7:0] ares8;
  assign la = st_q.lat.a_lo;
  assign lb = st_q.lat.b;
  assign lw = {st_q.lat.a_hi, st_q.lat.a_lo};
  assign lc = st_q.lat.flags[EAL_FLG_C];
  assign lop = st_q.lat.op;
  assign lf = st_q.lat.flags;
  assign af = alu_out.flags;
  assign ares = alu_out.res;
  assign ares8 = alu_out.res[EAL_B_MSB:0];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_sum_carry: assert property (commit && lop == EAL_OP_SUM_CARRY_REGS |->
    ares8 == 8'(la + lb + {7'h00, lc}) &&
    af[EAL_FLG_C] == (({1'b0, la} + {1'b0, lb} + {8'h00, lc}) > 9'h0FF))
    else $error("sum with carry wrong");
  a_word_sum: assert property (commit && lop == EAL_OP_WORD_IMM_SUM |->
    ares == 16'(lw + {8'h00, lb}) && af[EAL_FLG_S] == (af[EAL_FLG_N] ^ af[EAL_FLG_V]))
    else $error("word sum wrong");
  a_long_timing: assert property (start && eal_op_cycles(new_op) == EAL_CYC_LONG |=>
    !commit ##1 commit) else $error("two-cycle operation mistimed");
  a_short_timing: assert property (start && eal_op_cycles(new_op) == EAL_CYC_SHORT |=>
    commit) else $error("one-cycle operation mistimed");
  a_diff_const: assert property (commit && lop == EAL_OP_DIFF_CONST |->
    ares8 == 8'(la - lb) && af[EAL_FLG_C] == (lb > la)) else $error("constant difference wrong");
  a_diff_borrow: assert property (commit && lop == EAL_OP_DIFF_BORROW_REGS |->
    ares8 == 8'(la - lb - {7'h00, lc}) &&
    af[EAL_FLG_C] == (({1'b0, lb} + {8'h00, lc}) > {1'b0, la}))
    else $error("borrow difference wrong");
  a_borrow_half: assert property (commit && lop == EAL_OP_DIFF_BORROW_CONST |->
    af[EAL_FLG_H] == (({1'b0, lb[3:0]} + {4'h0, lc}) > {1'b0, la[3:0]}))
    else $error("half borrow wrong");
  a_word_diff: assert property (commit && lop == EAL_OP_WORD_IMM_DIFF |->
    ares == 16'(lw - {8'h00, lb}) && af[EAL_FLG_C] == ({8'h00, lb} > lw))
    else $error("word difference wrong");
  a_conj_flags: assert property (commit && lop == EAL_OP_CONJ_WITH_CONST |->
    ares8 == (la & lb) && !af[EAL_FLG_V] && af[EAL_FLG_C] == lc && af[EAL_FLG_H] == lf[EAL_FLG_H])
    else $error("conjunction wrong");
  a_xor_zero: assert property (commit && lop == EAL_OP_XOR_REGS |->
    ares8 == (la ^ lb) && af[EAL_FLG_Z] == (la == lb)) else $error("xor wrong");
  a_set_mask: assert property (commit && lop == EAL_OP_SET_MASK_BITS |->
    ares8 == (la | lb) && af[EAL_FLG_N] == (la[7] | lb[7])) else $error("set mask wrong");
  a_clear_mask: assert property (commit && lop == EAL_OP_CLEAR_MASK_BITS |->
    ares8 == (la & ~lb)) else $error("clear mask wrong");
  a_sign_check: assert property (commit && lop == EAL_OP_ZERO_SIGN_CHECK |->
    ares8 == la && af[EAL_FLG_Z] == (la == 8'h00) && af[EAL_FLG_N] == la[7])
    else $error("zero-sign check wrong");
  a_invert: assert property (commit && lop == EAL_OP_INVERT |->
    ares8 == ~la && af[EAL_FLG_C] && !af[EAL_FLG_V]) else $error("invert wrong");
  a_zero_fill: assert property (commit && lop == EAL_OP_ZERO_FILL |->
    ares8 == 8'h00 && af[EAL_FLG_Z] && !af[EAL_FLG_N]) else $error("zero fill wrong");
  a_signed_prod: assert property (commit && lop == EAL_OP_SIGNED_PRODUCT |->
    $signed(ares) == $signed(la) * $signed(lb) && af[5:2] == lf[5:2])
    else $error("signed product wrong");
  a_flags_frozen: assert property (busy && !commit |=> $stable(st_q.flags))
    else $error("flags moved mid-operation");
  a_commit_sync: assert property (commit |=> st_q.done && st_q.res == $past(ares) &&
    st_q.flags == $past(af)) else $error("result and flags not written together");

  // destination write and flags left alone, per operation
  a_sum_plain: assert property (commit && lop == EAL_OP_SUM_REGS |->
    ares8 == 8'(la + lb) && af[EAL_FLG_S] == lf[EAL_FLG_S] &&
    af[EAL_FLG_H] == (({1'b0, la[3:0]} + {1'b0, lb[3:0]}) > 5'h0F))
    else $error("plain sum wrong");
  a_diff_regs: assert property (commit && lop == EAL_OP_DIFF_REGS |->
    ares8 == 8'(la - lb) && af[EAL_FLG_Z] == (la == lb) && af[EAL_FLG_C] == (lb > la))
    else $error("register difference wrong");
  a_borrow_const: assert property (commit && lop == EAL_OP_DIFF_BORROW_CONST |->
    ares8 == 8'(la - lb - {7'h00, lc}) && af[EAL_FLG_S] == lf[EAL_FLG_S])
    else $error("borrow constant wrong");
  a_conj_regs: assert property (commit && lop == EAL_OP_CONJ_REGS |->
    ares8 == (la & lb) && af[EAL_FLG_N] == (la[7] & lb[7]) && af[EAL_FLG_C] == lc)
    else $error("register conjunction wrong");
  a_disj_regs: assert property (commit && lop == EAL_OP_DISJ_REGS |->
    ares8 == (la | lb) && af[EAL_FLG_Z] == (la == 8'h00 && lb == 8'h00))
    else $error("register disjunction wrong");
  a_disj_const: assert property (commit && lop == EAL_OP_DISJ_WITH_CONST |->
    ares8 == (la | lb) && !af[EAL_FLG_V] && af[EAL_FLG_C] == lc)
    else $error("constant disjunction wrong");
  a_invert_flags: assert property (commit && lop == EAL_OP_INVERT |->
    af[EAL_FLG_N] == !la[7] && af[EAL_FLG_H] == lf[EAL_FLG_H]) else $error("invert flags wrong");
  a_plain_prod: assert property (commit && lop == EAL_OP_UNSIGNED_PRODUCT |->
    int'(ares) == int'(la) * int'(lb) && af[EAL_FLG_C] == (int'(ares) >= 32768))
    else $error("unsigned product wrong");
  a_mixed_prod: assert property (commit && lop == EAL_OP_MIXED_SIGN_PRODUCT |->
    ares == 16'(int'($signed(la)) * int'(lb)) && af[EAL_FLG_Z] == (la == 8'h00 || lb == 8'h00))
    else $error("mixed product wrong");
  a_word_keeps: assert property (commit && eal_op_word(lop) |->
    af[EAL_FLG_H] == lf[EAL_FLG_H]) else $error("word operation moved half carry");
  a_word_dest: assert property (commit && eal_op_word(lop) |=>
    {st_q.dst_hi, st_q.dst_lo} == $past(ares)) else $error("word destination wrong");
  a_byte_dest: assert property (commit && !eal_op_word(lop) && !eal_op_product(lop) |=>
    st_q.dst_lo == $past(ares8) && $stable(st_q.dst_hi)) else $error("byte destination wrong");
  a_prod_dest: assert property (commit && eal_op_product(lop) |=>
    $stable({st_q.dst_hi, st_q.dst_lo})) else $error("product wrote the destination");

  c_word_sum: cover property (commit && lop == EAL_OP_WORD_IMM_SUM);
  c_neg_product: cover property (commit && lop == EAL_OP_MIXED_SIGN_PRODUCT && af[EAL_FLG_C]);
  c_refused: cover property (wr_fire && busy && st_d.refused);
  c_slverr: cover property (st_q.rsp.rvalid && st_q.rsp.rresp == EAL_RESP_SLVERR);

endmodule
`default_nettype wire

// ===== eal_host.sv
// eal_host.sv: register-bus master standing in for the decoder side.
// assumes: wr and rd are called from one process, never overlapping.
`timescale 1ns/100ps
`default_nettype none
module eal_host (
  input wire logic aclk,
  output var eal_pkg::eal_axi_req_t axi_req,
  input wire eal_pkg::eal_axi_rsp_t axi_rsp
);
  import eal_pkg::*;
  initial axi_req = '0;
  // bready rides with the request, so no edge with bvalid can slip by
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    axi_req <= {1'b1, a, 1'b1, v, 4'hF, 1'b1, 10'h000};
    do begin
      @(posedge aclk);
      if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready) begin
        axi_req.wvalid <= 1'b0;
        // released data must not look valid
        axi_req.wdata <= ~v;
      end
    end while (!axi_rsp.bvalid);
    r = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
    end while (!axi_rsp.rvalid);
    v = axi_rsp.rdata;
    r = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== eal_unit_tb.sv
// eal_unit_tb.sv: self-checking bench for the arithmetic/logic unit.
// assumes: eal_pkg, eal_unit and eal_host are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module eal_unit_tb;
  import eal_pkg::*;
  logic aclk;
  logic aresetn;
  eal_axi_req_t axi_req;
  eal_axi_rsp_t axi_rsp;
  int mismatches;
  int comparisons;
  int cycles;
  logic [31:0] d;
  logic [1:0] r;
  eal_unit dut (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp));
  eal_host host (.aclk(aclk), .axi_req(axi_req), .axi_rsp(axi_rsp));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // about 30 cycles per operation; the ceiling leaves a wide margin
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic misc();
    host.rd(EAL_OFS_FLAGS, d, r);
    chk("flags reset", d, 32'h0000_0000);
    host.wr(8'h14, 32'hFFFF_FFFF, r);
    chk("unmapped bresp", {30'h0, r}, {30'h0, EAL_RESP_SLVERR});
    host.rd(8'h14, d, r);
    chk("unmapped rdata", d, 32'h0000_0000);
    chk("unmapped rresp", {30'h0, r}, {30'h0, EAL_RESP_SLVERR});
    host.wr(EAL_OFS_CTRL, 32'h0000_0115, r);
    host.rd(EAL_OFS_STATUS, d, r);
    chk("refused", d, 32'h0000_0004);
    host.wr(EAL_OFS_STATUS, 32'h0000_0004, r);
    host.rd(EAL_OFS_FLAGS, d, r);
    chk("flags kept", d, 32'h0000_0000);
  endtask
  // v is {source, dest high, dest low}; f flags in, e flags out, x result
  task automatic op(input logic [4:0] o, input logic [23:0] v, input logic [5:0] f,
                    input logic [5:0] e, input logic [15:0] x);
    logic [23:0] w;
    host.wr(EAL_OFS_OPER, {8'h00, v}, r);
    host.wr(EAL_OFS_FLAGS, {26'h0, f}, r);
    host.wr(EAL_OFS_CTRL, {23'h0, 1'b1, 3'h0, o}, r);
    chk("go bresp", {30'h0, r}, {30'h0, EAL_RESP_OKAY});
    do host.rd(EAL_OFS_STATUS, d, r); while (d[1] !== 1'b1);
    chk("status", d, 32'h0000_0002);
    host.wr(EAL_OFS_STATUS, 32'h0000_0002, r);
    host.rd(EAL_OFS_STATUS, d, r);
    chk("done cleared", d, 32'h0000_0000);
    host.rd(EAL_OFS_RESULT, d, r);
    chk("result", d, {16'h0, x});
    chk("result rresp", {30'h0, r}, {30'h0, EAL_RESP_OKAY});
    host.rd(EAL_OFS_FLAGS, d, r);
    chk("flags", d, {26'h0, e});
    // products leave the destination alone; word ops write both bytes
    w = (o >= 5'h12) ? v : (o == 5'h02 || o == 5'h07) ? {v[23:16], x} : {v[23:8], x[7:0]};
    host.rd(EAL_OFS_OPER, d, r);
    chk("oper", d, {8'h00, w});
  endtask
  initial begin
    aresetn = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    misc();
    op(5'h01, 24'h01_000F, 6'h11, 6'h30, 16'h0011);
    op(5'h00, 24'h01_007F, 6'h00, 6'h2C, 16'h0080);
    op(5'h02, 24'h01_FFFF, 6'h20, 6'h23, 16'h0000);
    op(5'h04, 24'h01_0010, 6'h00, 6'h20, 16'h000F);
    op(5'h03, 24'h01_0080, 6'h00, 6'h28, 16'h007F);
    op(5'h05, 24'h00_0000, 6'h01, 6'h25, 16'h00FF);
    op(5'h06, 24'h01_0000, 6'h01, 6'h25, 16'h00FE);
    op(5'h07, 24'h01_8000, 6'h00, 6'h18, 16'h7FFF);
    op(5'h08, 24'h81_33FF, 6'h00, 6'h04, 16'h0081);
    op(5'h09, 24'h0F_00F0, 6'h00, 6'h02, 16'h0000);
    op(5'h0A, 24'h00_0000, 6'h08, 6'h02, 16'h0000);
    op(5'h0B, 24'h80_0000, 6'h00, 6'h04, 16'h0080);
    op(5'h0C, 24'hFF_00F0, 6'h08, 6'h00, 16'h000F);
    op(5'h0E, 24'h02_0001, 6'h21, 6'h21, 16'h0003);
    op(5'h0F, 24'h0F_00FF, 6'h29, 6'h25, 16'h00F0);
    op(5'h10, 24'h00_0080, 6'h02, 6'h04, 16'h0080);
    op(5'h0D, 24'h00_00FF, 6'h20, 6'h23, 16'h0000);
    op(5'h11, 24'h00_5A5A, 6'h04, 6'h02, 16'h0000);
    op(5'h12, 24'hFF_00FF, 6'h0C, 6'h0D, 16'hFE01);
    op(5'h13, 24'h02_00FF, 6'h00, 6'h01, 16'hFFFE);
    op(5'h14, 24'h02_0080, 6'h02, 6'h01, 16'hFF00);
    stop_test();
  end
endmodule
`default_nettype wire
